// ===== hw/csbi_pkg.sv
// shared constants of the cpu system bus interface
package csbi_pkg;
   // register map, 36-bit physical byte addresses
   localparam logic [35:0] CSBI_MODE_ADDR = 36'hF_FF10_0000;
   localparam logic [35:0] CSBI_STAT_ADDR = 36'hF_FF10_0008;
   // system_interface_mode fields
   localparam int CSBI_DRATE_BIT = 0;
   localparam int CSBI_WMODE_LSB = 1;
   localparam int CSBI_TOEN_BIT = 3;
   localparam int CSBI_TOVAL_LSB = 4;
   localparam int CSBI_TOVAL_W = 16;
   localparam logic [15:0] CSBI_TOVAL_RESET = 16'hFFFF;
   localparam logic [1:0] CSBI_WMODE_RESET = 2'h0;
   // write protocol codes
   localparam logic [1:0] CSBI_WMODE_LEGACY = 2'h0;
   localparam logic [1:0] CSBI_WMODE_PIPE = 2'h2;
   localparam logic [1:0] CSBI_WMODE_REISSUE = 2'h3;
   // status fields
   localparam int CSBI_ST_ERR_BIT = 0;
   localparam int CSBI_ST_LEGACY_BIT = 1;
   localparam int CSBI_ST_PEND_BIT = 2;
   localparam int CSBI_ST_TOUT_BIT = 3;
   // command_id_bus layout in legacy mode
   localparam int CSBI_CMD_DATA_BIT = 4;
   localparam int CSBI_CMD_WRITE_BIT = 3;
   localparam int CSBI_CMD_BLOCK_BIT = 2;
   localparam int CSBI_ID_LAST_BIT = 3;
   localparam int CSBI_ID_ERR_BIT = 1;
   localparam int CSBI_ID_NOCHK_BIT = 0;
   localparam logic [1:0] CSBI_BLOCK_CODE = 2'h1;
   // element sizes
   localparam logic [1:0] CSBI_SIZE_BYTE = 2'h0;
   localparam logic [1:0] CSBI_SIZE_HALF = 2'h1;
   localparam logic [1:0] CSBI_SIZE_TRI = 2'h2;
   localparam logic [1:0] CSBI_SIZE_WORD = 2'h3;
   // timing counts in clock cycles
   localparam logic [1:0] CSBI_PACE_IDLE = 2'h2;
   localparam logic [1:0] CSBI_LEGACY_GAP = 2'h2;
   localparam int CSBI_GOOD_ERR_DELAY = 2;
   localparam int CSBI_CHECK_ERR_DELAY = 3;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WDATA, ST_RWAIT, ST_RELEASE} csbi_state_e;
endpackage

// ===== hw/csbi_addr_align.sv
// address alignment for address cycles
module csbi_addr_align
   import csbi_pkg::*;
(
   input wire logic [31:0] addr,
   input wire logic block,
   input wire logic [1:0] size,
   output logic [31:0] aligned
);
   wire clear_two = block || (size == CSBI_SIZE_WORD);
   wire clear_one = (size == CSBI_SIZE_HALF);
   // single byte and tri-byte requests keep the exact byte address
   assign aligned = {addr[31:2], addr[1] & ~clear_two, addr[0] & ~(clear_two | clear_one)};
endmodule

// ===== hw/csbi_data_check.sv
// read data error detection with fixed reporting latency
module csbi_data_check
   import csbi_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic word_valid,
   input wire logic [DATA_W-1:0] data,
   input wire logic [DATA_W/8-1:0] check,
   input wire logic err_flag,
   input wire logic no_check,
   input wire logic block,
   output logic err_pulse,
   output logic inv_pulse
);
   logic [DATA_W/8-1:0] lane_bad;
   logic [CSBI_GOOD_ERR_DELAY-1:0] gd_q, gd_blk_q;
   logic [CSBI_CHECK_ERR_DELAY-1:0] ck_q, ck_blk_q;

   // even parity per byte lane
   for (genvar i = 0; i < DATA_W / 8; i++) begin : g_lane
      assign lane_bad[i] = ^{data[8*i+:8], check[i]};
   end

   wire gd_now = word_valid && err_flag;
   wire ck_now = word_valid && !no_check && (|lane_bad);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gd_q <= '0;
         gd_blk_q <= '0;
         ck_q <= '0;
         ck_blk_q <= '0;
      end else begin
         gd_q <= {gd_q[CSBI_GOOD_ERR_DELAY-2:0], gd_now};
         gd_blk_q <= {gd_blk_q[CSBI_GOOD_ERR_DELAY-2:0], gd_now && block};
         ck_q <= {ck_q[CSBI_CHECK_ERR_DELAY-2:0], ck_now};
         ck_blk_q <= {ck_blk_q[CSBI_CHECK_ERR_DELAY-2:0], ck_now && block};
      end
   end

   // one merged pulse: the cause is deliberately not told apart
   assign err_pulse = gd_q[CSBI_GOOD_ERR_DELAY-1] | ck_q[CSBI_CHECK_ERR_DELAY-1];
   assign inv_pulse = gd_blk_q[CSBI_GOOD_ERR_DELAY-1] | ck_blk_q[CSBI_CHECK_ERR_DELAY-1];

   check_err_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
      ck_now |-> ##3 err_pulse)
      else $error("check bit error not reported three cycles later");
endmodule

// ===== hw/csbi_bus_if.sv
// processor side system bus interface: requests, mode register, read errors
//
// Functional notes
// - address cycles carry the full 32-bit physical address
// - block request addresses have their low two bits cleared
// - single requests align to element size; byte and tri-byte keep exact address
// - mode register lives at a fixed address, full word access only
// - two-bit write mode: 00 legacy, 10 pipelined, 11 reissue; resets to 00
// - data rate bit set puts two idle cycles between block write words
// - a zero timeout value may raise a timeout regardless of enable
// - timeout counter is stopped in standard protocol mode
// - good-data flag checked on every returned word, error raises bus error
// - check bits verified on every returned word without the no-check bit set, failure raises bus error
// - good-data error reported two cycles later, check error three cycles later
// - block refill error invalidates the line, cause is not reported
// - protocol select low means legacy protocol, high means standard protocol
// - legacy mode has no protocol error output; read timeout raises bus error
// - legacy mode drives upper command pins and read-ready output low
// - cpu valid low marks a valid cpu bus cycle
// - cpu bus release low hands the bus to the agent
// - command bit 4 low marks address cycles, high marks data cycles
// - no new request while a read awaits its data
module csbi_bus_if
   import csbi_pkg::*;
#(
   parameter int BLOCK_WORDS = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [35:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_block,
   input wire logic [1:0] req_size,
   input wire logic [31:0] req_addr,
   input wire logic wd_valid,
   output logic wd_ready,
   input wire logic [31:0] wd_data,
   output logic rd_valid,
   output logic [31:0] rd_data,
   output logic rd_last,
   output logic bus_error,
   output logic line_invalid,
   input wire logic [31:0] shared_addr_data_bus_in,
   output logic [31:0] shared_addr_data_bus_out,
   output logic shared_addr_data_bus_oe,
   input wire logic [4:0] command_id_bus_in,
   output logic [4:0] command_id_bus_out,
   output logic command_id_bus_oe,
   output logic [3:0] command_id_hi_out,
   input wire logic [3:0] shared_check_bits_in,
   input wire logic agent_valid_n,
   output logic cpu_valid_n,
   input wire logic agent_ownership_request_n,
   output logic cpu_bus_release_n,
   input wire logic agent_accept_ready_n,
   output logic read_ready_out_n,
   input wire logic protocol_select_n
);
   localparam int IN_W = 45;
   localparam logic [3:0] LAST_IDX = 4'(BLOCK_WORDS - 1);

   csbi_state_e state;
   logic [IN_W-1:0] sync1, sync2;
   logic drate, to_en, err_seen, tout_seen;
   logic [1:0] wmode, gap_cnt, pace_cnt, cur_size;
   logic [15:0] toval, to_cnt;
   logic cur_write, cur_block, to_err;
   logic [3:0] word_cnt;
   logic [31:0] aligned;
   logic chk_err, chk_inv;

   // two-flop capture of every pin input
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1 <= '1;
         sync2 <= '1;
      end else begin
         sync1 <= {shared_addr_data_bus_in, command_id_bus_in, shared_check_bits_in, agent_valid_n,
                   agent_ownership_request_n, agent_accept_ready_n, protocol_select_n};
         sync2 <= sync1;
      end
   end

   wire [31:0] ad_s = sync2[44:13];
   wire [4:0] cmd_s = sync2[12:8];
   wire [3:0] chk_s = sync2[7:4];
   wire agent_valid_s = !sync2[3];
   wire own_req_s = !sync2[2];
   wire accept_s = !sync2[1];
   wire legacy_s = !sync2[0];

   // register decode; the plain port always moves a whole word
   wire mode_sel = (reg_addr == CSBI_MODE_ADDR);
   wire stat_sel = (reg_addr == CSBI_STAT_ADDR);
   wire mode_wr = reg_wr && mode_sel;
   wire stat_wr = reg_wr && stat_sel;
   wire [31:0] mode_word = {12'h000, toval, to_en, wmode, drate};
   wire [31:0] stat_word = {28'h0000000, tout_seen, (state == ST_RWAIT), legacy_s, err_seen};
   wire [31:0] rd_mux = mode_sel ? mode_word : (stat_sel ? stat_word : 32'h0000_0000);

   // request and data handshakes
   wire req_take = req_valid && req_ready;
   assign req_ready = (state == ST_IDLE) && !own_req_s && accept_s && (gap_cnt == 2'h0);
   assign wd_ready = cur_write && (state == ST_ADDR || state == ST_WDATA) && (pace_cnt == 2'h0);
   wire wd_take = wd_valid && wd_ready;
   wire [3:0] end_idx = cur_block ? LAST_IDX : 4'h0;
   wire xfer_last = (word_cnt == end_idx);
   wire [1:0] size_code = req_block ? CSBI_BLOCK_CODE : req_size;
   wire [4:0] addr_cmd = {1'b0, req_write, req_block, size_code};
   wire [4:0] data_id = {1'b1, !xfer_last, 3'h0};
   wire [1:0] next_gap = (wmode == CSBI_WMODE_PIPE || wmode == CSBI_WMODE_REISSUE) ?
                         2'h0 : CSBI_LEGACY_GAP;
   wire [1:0] next_pace = (cur_block && drate) ? CSBI_PACE_IDLE : 2'h0;

   // read reply and timeout
   wire rdata_in = (state == ST_RWAIT) && agent_valid_s && cmd_s[CSBI_CMD_DATA_BIT];
   wire timeout_hit = legacy_s && (to_en || toval == 16'h0000) && (to_cnt >= toval);

   csbi_addr_align u_align (
      .addr(req_addr),
      .block(req_block),
      .size(req_size),
      .aligned(aligned)
   );

   csbi_data_check #(.DATA_W(32)) u_check (
      .clk(clk),
      .rst_n(rst_n),
      .word_valid(rdata_in),
      .data(ad_s),
      .check(chk_s),
      .err_flag(cmd_s[CSBI_ID_ERR_BIT]),
      .no_check(cmd_s[CSBI_ID_NOCHK_BIT]),
      .block(cur_block),
      .err_pulse(chk_err),
      .inv_pulse(chk_inv)
   );

   // a timeout is just another bus error; no separate protocol error pin
   assign bus_error = chk_err | to_err;
   assign line_invalid = chk_inv | (to_err & cur_block);

   // mode register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drate <= 1'b0;
         wmode <= CSBI_WMODE_RESET;
         to_en <= 1'b0;
         toval <= CSBI_TOVAL_RESET;
      end else if (mode_wr) begin
         drate <= reg_wdata[CSBI_DRATE_BIT];
         wmode <= reg_wdata[CSBI_WMODE_LSB+:2];
         to_en <= reg_wdata[CSBI_TOEN_BIT];
         toval <= reg_wdata[CSBI_TOVAL_LSB+:CSBI_TOVAL_W];
      end
   end

   // sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_seen <= 1'b0;
         tout_seen <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         err_seen <= (err_seen && !(stat_wr && reg_wdata[CSBI_ST_ERR_BIT])) || bus_error;
         tout_seen <= (tout_seen && !(stat_wr && reg_wdata[CSBI_ST_TOUT_BIT])) || to_err;
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // legacy-mode fixed pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         command_id_hi_out <= 4'h0;
         read_ready_out_n <= 1'b1;
      end else begin
         command_id_hi_out <= 4'h0;
         read_ready_out_n <= !legacy_s;
      end
   end

   // transaction engine; every bus output leaves a flip-flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         shared_addr_data_bus_out <= 32'h0000_0000;
         shared_addr_data_bus_oe <= 1'b0;
         command_id_bus_out <= 5'h00;
         command_id_bus_oe <= 1'b0;
         cpu_valid_n <= 1'b1;
         cpu_bus_release_n <= 1'b1;
         rd_valid <= 1'b0;
         rd_data <= 32'h0000_0000;
         rd_last <= 1'b0;
         to_err <= 1'b0;
         to_cnt <= 16'h0000;
         gap_cnt <= 2'h0;
         pace_cnt <= 2'h0;
         word_cnt <= 4'h0;
         cur_write <= 1'b0;
         cur_block <= 1'b0;
         cur_size <= 2'h0;
      end else begin
         cpu_valid_n <= 1'b1;
         shared_addr_data_bus_oe <= 1'b0;
         command_id_bus_oe <= 1'b0;
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         to_err <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (gap_cnt != 2'h0) gap_cnt <= gap_cnt - 2'h1;
               if (own_req_s) begin
                  cpu_bus_release_n <= 1'b0;
                  state <= ST_RELEASE;
               end else if (req_take) begin
                  cur_write <= req_write;
                  cur_block <= req_block;
                  cur_size <= size_code;
                  word_cnt <= 4'h0;
                  pace_cnt <= 2'h0;
                  shared_addr_data_bus_out <= aligned;
                  command_id_bus_out <= addr_cmd;
                  shared_addr_data_bus_oe <= 1'b1;
                  command_id_bus_oe <= 1'b1;
                  cpu_valid_n <= 1'b0;
                  state <= ST_ADDR;
               end
            end
            ST_ADDR, ST_WDATA: begin
               if (!cur_write) begin
                  // agent owns the bus by default while the read is pending
                  cpu_bus_release_n <= 1'b0;
                  to_cnt <= 16'h0000;
                  state <= ST_RWAIT;
               end else if (wd_take) begin
                  shared_addr_data_bus_out <= wd_data;
                  command_id_bus_out <= data_id;
                  shared_addr_data_bus_oe <= 1'b1;
                  command_id_bus_oe <= 1'b1;
                  cpu_valid_n <= 1'b0;
                  word_cnt <= word_cnt + 4'h1;
                  pace_cnt <= next_pace;
                  if (xfer_last) begin
                     gap_cnt <= next_gap;
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_WDATA;
                  end
               end else begin
                  if (pace_cnt != 2'h0) pace_cnt <= pace_cnt - 2'h1;
                  state <= ST_WDATA;
               end
            end
            ST_RWAIT: begin
               if (rdata_in) begin
                  rd_valid <= 1'b1;
                  rd_data <= ad_s;
                  rd_last <= xfer_last;
                  word_cnt <= word_cnt + 4'h1;
                  to_cnt <= 16'h0000;
                  // the whole block is taken even after a flagged word; only a timeout ends it early
                  if (xfer_last) begin
                     cpu_bus_release_n <= 1'b1;
                     state <= ST_IDLE;
                  end
               end else if (timeout_hit) begin
                  to_err <= 1'b1;
                  cpu_bus_release_n <= 1'b1;
                  state <= ST_IDLE;
               end else if (legacy_s) begin
                  to_cnt <= to_cnt + 16'h0001;
               end else begin
                  to_cnt <= 16'h0000;
               end
            end
            ST_RELEASE: begin
               if (!own_req_s) begin
                  cpu_bus_release_n <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence good_err_word;
      rdata_in && cmd_s[CSBI_ID_ERR_BIT];
   endsequence

   sequence paced_word;
      !cpu_valid_n && command_id_bus_out[CSBI_CMD_DATA_BIT] &&
      command_id_bus_out[CSBI_ID_LAST_BIT] && cur_block && drate;
   endsequence

   block_align_a: assert property (
      !cpu_valid_n && !command_id_bus_out[CSBI_CMD_DATA_BIT] &&
      command_id_bus_out[CSBI_CMD_BLOCK_BIT] |-> shared_addr_data_bus_out[1:0] == 2'h0)
      else $error("block address not word aligned");

   half_align_a: assert property (
      req_take && !req_block && req_size == CSBI_SIZE_HALF |=> shared_addr_data_bus_out[0] == 1'b0)
      else $error("half-word address not aligned");

   legacy_pins_a: assert property (
      legacy_s |=> command_id_hi_out == 4'h0 && !read_ready_out_n)
      else $error("legacy fixed pins not low");

   no_issue_pend_a: assert property (
      state == ST_RWAIT |-> !req_ready)
      else $error("request accepted while read pending");

   timeout_stop_a: assert property (
      !legacy_s && state == ST_RWAIT |=> to_cnt == 16'h0000 && !to_err)
      else $error("timeout counter ran in standard mode");

   zero_timeout_a: assert property (
      state == ST_RWAIT && legacy_s && toval == 16'h0000 && !rdata_in |=> bus_error)
      else $error("zero timeout value did not raise error");

   good_err_delay_a: assert property (
      good_err_word |-> ##2 bus_error)
      else $error("good-data error not reported two cycles later");

   block_pace_a: assert property (
      paced_word |=> cpu_valid_n [*2])
      else $error("block write pacing idle cycles missing");

   valid_drive_a: assert property (
      !cpu_valid_n |-> shared_addr_data_bus_oe && command_id_bus_oe && cpu_bus_release_n)
      else $error("valid asserted without driving the bus");
endmodule

// ===== testbench/csbi_agent_model.sv
// behavioural external agent that answers read requests on the shared bus
module csbi_agent_model
   import csbi_pkg::*;
#(
   parameter int BW = 8
)
(
   input wire logic clk,
   input wire logic cpu_valid_n,
   input wire logic cpu_bus_release_n,
   input wire logic [4:0] command_id_bus_out,
   input wire logic [7:0] err_idx,
   input wire logic [7:0] par_idx,
   input wire logic [7:0] delay,
   input wire logic own_ask,
   output logic [31:0] shared_addr_data_bus_in,
   output logic [4:0] command_id_bus_in,
   output logic [3:0] shared_check_bits_in,
   output logic agent_valid_n,
   output logic agent_ownership_request_n,
   output logic agent_accept_ready_n,
   output logic bad_word
);
   timeunit 1ns;
   timeprecision 100ps;
   int n;
   logic [31:0] d;
   initial begin
      agent_valid_n = 1'b1;
      // no processor request pin exists here; accept ready is simply tied low
      agent_accept_ready_n = 1'b0;
      shared_addr_data_bus_in = 32'h0;
      command_id_bus_in = 5'h0;
      shared_check_bits_in = 4'h0;
      bad_word = 1'b0;
   end
   // ownership is asked only when the bench says so
   always @(posedge clk) agent_ownership_request_n <= !own_ask;
   always begin
      @(posedge clk);
      if (cpu_valid_n === 1'b0 && command_id_bus_out[4:3] === 2'h0) begin
         n = command_id_bus_out[2] ? BW : 1;
         // bounded: a read dropped by a timeout may never hand over the bus
         for (int k = 0; k < 50 && cpu_bus_release_n !== 1'b0; k++) @(posedge clk);
         repeat (delay) @(posedge clk);
         for (int i = 0; i < n && cpu_bus_release_n === 1'b0; i++) begin
            d = 32'hA500_0000 + 32'(i);
            agent_valid_n <= 1'b0;
            shared_addr_data_bus_in <= d;
            command_id_bus_in <= {1'b1, i != n - 1, 1'b0, i == int'(err_idx), 1'b0};
            shared_check_bits_in <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0] ^ (i == int'(par_idx))};
            bad_word <= (i == int'(err_idx)) || (i == int'(par_idx));
            @(posedge clk);
         end
         // whole block goes out even after a flagged word; released data and command lines show no stale data, check bits keep their last value
         agent_valid_n <= 1'b1;
         shared_addr_data_bus_in <= ~d;
         command_id_bus_in <= ~command_id_bus_in;
         bad_word <= 1'b0;
      end
   end
endmodule

// ===== testbench/csbi_bus_if_tb.sv
// self-checking bench of the cpu system bus interface
module csbi_bus_if_tb
   import csbi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, reg_wr, reg_rd, req_valid, req_ready, req_write, req_block, wd_valid;
   logic wd_ready, rd_valid, rd_last, bus_error, line_invalid, bad_word;
   logic [35:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, req_addr, wd_data, rd_data, sad_in, sad_out;
   logic [1:0] req_size;
   logic sad_oe, cmd_oe, agent_valid_n, cpu_valid_n, own_n, cpu_bus_release_n, acc_n;
   logic read_ready_out_n, protocol_select_n, own_ask;
   logic [4:0] cmd_in, cmd_out;
   logic [3:0] cmd_hi, chk_in;
   logic [7:0] err_idx, par_idx, delay;
   int bad_count, tests_run;
   csbi_bus_if #(.BLOCK_WORDS(8)) csbi_bus_if_inst (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_block(req_block), .req_size(req_size), .req_addr(req_addr),
      .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_last(rd_last), .bus_error(bus_error), .line_invalid(line_invalid),
      .shared_addr_data_bus_in(sad_in), .shared_addr_data_bus_out(sad_out),
      .shared_addr_data_bus_oe(sad_oe), .command_id_bus_in(cmd_in),
      .command_id_bus_out(cmd_out), .command_id_bus_oe(cmd_oe), .command_id_hi_out(cmd_hi),
      .shared_check_bits_in(chk_in), .agent_valid_n(agent_valid_n), .cpu_valid_n(cpu_valid_n),
      .agent_ownership_request_n(own_n), .cpu_bus_release_n(cpu_bus_release_n),
      .agent_accept_ready_n(acc_n), .read_ready_out_n(read_ready_out_n),
      .protocol_select_n(protocol_select_n));
   csbi_agent_model #(.BW(8)) csbi_agent_model_inst (
      .clk(clk), .cpu_valid_n(cpu_valid_n), .cpu_bus_release_n(cpu_bus_release_n),
      .command_id_bus_out(cmd_out), .err_idx(err_idx), .par_idx(par_idx), .delay(delay),
      .shared_addr_data_bus_in(sad_in), .command_id_bus_in(cmd_in), .shared_check_bits_in(chk_in),
      .agent_valid_n(agent_valid_n), .agent_ownership_request_n(own_n),
      .agent_accept_ready_n(acc_n), .bad_word(bad_word), .own_ask(own_ask));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rw(input logic [35:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rr(input logic [35:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   function automatic logic [31:0] al(input logic b, input logic [1:0] s, input logic [31:0] a);
      if (b || s == CSBI_SIZE_WORD) return a & 32'hFFFF_FFFC;
      if (s == CSBI_SIZE_HALF) return a & 32'hFFFF_FFFE;
      return a;
   endfunction
   // request held until the edge that sees req_ready; returns just after that edge
   task automatic issue(input logic w, input logic b, input logic [1:0] s, input logic [31:0] a);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_block <= b;
      req_size <= s;
      req_addr <= a;
      @(negedge clk);
      for (int k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clk);
      @(posedge clk);
      req_valid <= 1'b0;
   endtask
   // one read: address cycle checked, then error cycle, flagged word cycle and words counted
   task automatic rd_txn(input logic b, input logic [1:0] s, input logic [31:0] a,
                         output int tw, output int te, output int nrd, output logic inv);
      issue(1'b0, b, s, a);
      @(negedge clk);
      chk("rd_addr", sad_out, al(b, s, a));
      chk("addr_cycle", {cpu_valid_n, cmd_out[4], sad_oe, cmd_oe}, 4'h3);
      tw = -1;
      te = -1;
      nrd = 0;
      inv = 1'b0;
      for (int k = 1; k < 60; k++) begin
         @(negedge clk);
         if (bad_word === 1'b1 && tw < 0) tw = k;
         if (bus_error === 1'b1 && te < 0) te = k;
         if (bus_error === 1'b1) inv = line_invalid;
         if (rd_valid === 1'b1) nrd++;
         if (k == 1) chk("rd_release", cpu_bus_release_n, 1'b0);
         if (rd_valid === 1'b1) chk("rd_last", rd_last, nrd == (b ? 8 : 1));
         if (rd_valid === 1'b1 && nrd == 1) chk("rd_data", rd_data, 32'hA500_0000);
      end
   endtask
   task automatic t_regs;
      logic [31:0] d;
      rr(CSBI_MODE_ADDR, d);
      chk("mode_reset", d, 32'h000F_FFF0);
      rw(CSBI_MODE_ADDR, 32'hFFF1_2347);
      rr(CSBI_MODE_ADDR, d);
      chk("mode_rw", d, 32'h0001_2347);
      rw(CSBI_MODE_ADDR + 36'h4, 32'h0000_0002);
      rr(CSBI_MODE_ADDR + 36'h4, d);
      chk("unmapped", d, 32'h0);
      rr(CSBI_MODE_ADDR, d);
      chk("mode_kept", d, 32'h0001_2347);
      rw(CSBI_MODE_ADDR, 32'h000F_FFF0);
   endtask
   task automatic t_reads;
      int tw, te, n;
      logic inv;
      for (int s = 0; s < 4; s++) begin
         rd_txn(1'b0, 2'(s), 32'h1357_9BDF, tw, te, n, inv);
         chk("single_words", 32'(n), 32'h1);
      end
      // flagged word mid-block, then check-bit failures on a single and a block read
      err_idx = 8'h3;
      rd_txn(1'b1, 2'h0, 32'h0000_4006, tw, te, n, inv);
      chk("gd_lat", 32'(te - tw), 32'h4);
      chk("gd_words", 32'(n), 32'h8);
      chk("gd_inv", inv, 1'b1);
      err_idx = 8'hFF;
      for (int b = 0; b < 2; b++) begin
         par_idx = b ? 8'h5 : 8'h0;
         rd_txn(b[0], 2'h3, 32'h0000_5001, tw, te, n, inv);
         chk("cb_lat", 32'(te - tw), 32'h5);
         chk("cb_inv", inv, b[0]);
      end
      par_idx = 8'hFF;
   endtask
   task automatic t_writes;
      int k;
      for (int m = 0; m < 3; m++) begin
         rw(CSBI_MODE_ADDR, {12'h0, 16'hFFFF, 1'b0, m == 0 ? 2'h0 : 2'(m + 1), 1'b0});
         issue(1'b1, 1'b0, CSBI_SIZE_WORD, 32'h0000_2002);
         for (k = 1; k < 30; k++) begin
            @(negedge clk);
            if (k == 1) chk("wr_addr", sad_out, 32'h0000_2000);
            if (k == 1) chk("wd_ready", wd_ready, 1'b1);
            if (k == 2) chk("wr_data", {cmd_out[4], cpu_valid_n, sad_out[15:0]}, 32'h2_5A01);
            if (k > 2 && req_ready === 1'b1) break;
         end
         chk("wr_gap", 32'(k == 4), {31'h0, m == 0});
      end
   endtask
   task automatic t_pace;
      int t0, t1, n;
      for (int r = 0; r < 2; r++) begin
         rw(CSBI_MODE_ADDR, 32'h000F_FFF4 | 32'(r));
         issue(1'b1, 1'b1, CSBI_SIZE_WORD, 32'h0000_3007);
         t0 = -1;
         t1 = -1;
         n = 0;
         for (int k = 1; k < 60; k++) begin
            @(negedge clk);
            if (k == 1) chk("blk_addr", sad_out, 32'h0000_3004);
            if (cpu_valid_n === 1'b0 && cmd_out[4] === 1'b1) begin
               n++;
               if (t0 < 0) t0 = k;
               else if (t1 < 0) t1 = k;
            end
         end
         chk("blk_words", 32'(n), 32'h8);
         chk("blk_space", 32'(t1 - t0), r ? 32'h3 : 32'h1);
      end
   endtask
   task automatic t_timeout;
      int tw, te, n;
      logic inv;
      logic [31:0] d;
      rw(CSBI_MODE_ADDR, 32'h0000_0000);
      delay = 8'd20;
      rd_txn(1'b0, 2'h3, 32'h0000_6000, tw, te, n, inv);
      chk("std_no_tout", 32'(te), 32'hFFFF_FFFF);
      @(posedge clk);
      protocol_select_n <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("legacy_pins", {cmd_hi, read_ready_out_n}, 32'h0);
      rd_txn(1'b0, 2'h3, 32'h0000_6000, tw, te, n, inv);
      chk("legacy_tout", 32'(te > 0 && te < 8), 32'h1);
      rr(CSBI_STAT_ADDR, d);
      chk("status", d, 32'hB);
      rw(CSBI_STAT_ADDR, 32'hF);
      rr(CSBI_STAT_ADDR, d);
      chk("status_clr", d, 32'h2);
      // ownership asked, then withdrawn: release follows, requests blocked meanwhile
      for (int a = 1; a >= 0; a--) begin
         @(posedge clk);
         own_ask <= a[0];
         repeat (5) @(posedge clk);
         @(negedge clk);
         chk("release", {cpu_bus_release_n, req_ready}, a ? 32'h0 : 32'h3);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, req_valid, req_write, req_block, wd_valid} = 7'h0;
      {reg_addr, reg_wdata, req_addr, req_size} = '0;
      wd_data = 32'h5A5A_5A01;
      protocol_select_n = 1'b1;
      own_ask = 1'b0;
      {err_idx, par_idx, delay} = {8'hFF, 8'hFF, 8'h2};
      bad_count = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_reads();
      @(posedge clk);
      wd_valid <= 1'b1;
      t_writes();
      t_pace();
      @(posedge clk);
      wd_valid <= 1'b0;
      t_timeout();
      complete_run();
   end
endmodule
